// [dv/dpc_checker.sv]
// concurrent checks on the host to controller link
`timescale 1ns/1ps
module dpc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic command_strobe,
  input wire logic device_select_bit,
  input wire logic [4:0] command_lines,
  input wire logic read_strobe,
  input wire logic accelerator_select,
  input wire logic phase_two_gate,
  input wire logic host_rdata_oe,
  input wire logic [2:0] drive_tag_lines,
  input wire logic [9:0] drive_tag_bus,
  input wire logic drive_init
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_start;
    $rose(command_strobe);
  endsequence
  sequence s_held;
    (command_strobe && device_select_bit && $stable(command_lines)) [*8];
  endsequence
  sequence s_preset_cmd;
    command_strobe && device_select_bit && command_lines == 5'h13;
  endsequence
  property p_hold;
    s_start |=> s_held;
  endproperty
  property p_gate;
    $rose(phase_two_gate) |-> phase_two_gate [*4] ##1 !phase_two_gate;
  endproperty
  property p_read_ans;
    $rose(read_strobe) && !accelerator_select |-> ##[1:8] host_rdata_oe;
  endproperty
  property p_oe;
    host_rdata_oe |-> read_strobe || $past(read_strobe, 6);
  endproperty
  property p_onehot;
    $onehot0(drive_tag_lines);
  endproperty
  property p_seek;
    $rose(drive_tag_lines[0]) |-> command_strobe && command_lines == 5'h09;
  endproperty
  property p_head;
    drive_tag_lines[1] |-> drive_tag_bus[9:5] == 5'h00 && drive_tag_bus[4:0] < 5'h0E;
  endproperty
  property p_func;
    drive_tag_lines[2] |-> drive_tag_bus == 10'h001 || drive_tag_bus == 10'h002
      || drive_tag_bus == 10'h004;
  endproperty
  property p_init;
    drive_init |-> s_preset_cmd ##1 !drive_init;
  endproperty
  property p_cmd_select;
    command_strobe |-> device_select_bit;
  endproperty
  property p_lines_steady;
    command_strobe && $past(command_strobe) |-> $stable(command_lines);
  endproperty
  a_hold: assert property (p_hold) else $error("strobe or lines moved early");
  a_gate: assert property (p_gate) else $error("phase two gate width wrong");
  a_read_ans: assert property (p_read_ans) else $error("read not answered");
  a_oe: assert property (p_oe) else $error("data bus driven without read");
  a_onehot: assert property (p_onehot) else $error("two tag lines at once");
  a_seek: assert property (p_seek) else $error("seek tag without address write");
  a_head: assert property (p_head) else $error("head tag with bad head");
  a_func: assert property (p_func) else $error("function tag with bad code");
  a_init: assert property (p_init) else $error("drive init without preset");
  a_cmd_select: assert property (p_cmd_select) else $error("strobe without select");
  a_lines_steady: assert property (p_lines_steady) else $error("lines moved under strobe");
endmodule

// [dv/testbench.sv]
// self-checking bench joining host end and controller end
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic [4:0] req_command = 5'h00;
  logic [31:0] req_wdata = 32'h0;
  logic req_ready, rsp_valid, irq_pending, auto_mode;
  logic [31:0] rsp_data, drive_address;
  logic [7:0] control_word;
  logic [4:0] sector_count, drive_status;
  logic [31:0] exp_q[$];
  logic [9:0] tag_val[3];
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  dpc_if bus();
  always #10 clk = ~clk;
  dpc_host i_dpc_host (.clk(clk), .rst(rst), .port(bus.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_command(req_command),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  dpc_ctrl i_dpc_ctrl (.clk(clk), .rst(rst), .port(bus.ctrl), .irq_pending(irq_pending),
    .auto_mode(auto_mode), .control_word(control_word), .drive_address(drive_address),
    .sector_count(sector_count), .drive_status(drive_status));
  dpc_checker u_chk (.clk(clk), .rst(rst), .command_strobe(bus.command_strobe),
    .device_select_bit(bus.device_select_bit), .command_lines(bus.command_lines),
    .read_strobe(bus.read_strobe), .accelerator_select(bus.accelerator_select),
    .phase_two_gate(bus.phase_two_gate), .host_rdata_oe(bus.host_rdata_oe),
    .drive_tag_lines(bus.drive_tag_lines), .drive_tag_bus(bus.drive_tag_bus),
    .drive_init(bus.drive_init));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one host request, then wait until its strobe has ended
  task automatic op(input logic rd, input logic [4:0] c, input logic [31:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_read <= rd;
    req_command <= c;
    req_wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 60);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((bus.command_strobe | bus.read_strobe) !== 1'b0 && n < 60);
    repeat (3) @(posedge clk);
  endtask
  // captures the bus value seen under each tag line
  always @(posedge clk) begin
    for (int k = 0; k < 3; k++) begin
      if (bus.drive_tag_lines[k] === 1'b1) tag_val[k] <= bus.drive_tag_bus;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(rsp_data, 32'hXXXXXXXX);
      else chk(rsp_data, exp_q.pop_front());
    end
  end
  initial begin
    logic [31:0] v, st;
    logic [31:0] w[4];
    logic [2:0] rc[4];
    bus.drive_sector_count = 5'h00;
    bus.drive_fault = 1'b0;
    bus.drive_seek_error = 1'b0;
    bus.drive_on_cylinder = 1'b0;
    bus.drive_ready = 1'b0;
    bus.drive_write_protect = 1'b0;
    rc = '{3'h0, 3'h1, 3'h4, 3'h5};
    v = $urandom(32'hF708);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    v = $urandom();
    {bus.drive_write_protect, bus.drive_ready, bus.drive_on_cylinder} <= v[9:7];
    {bus.drive_seek_error, bus.drive_fault, bus.drive_sector_count} <= v[6:0];
    @(posedge clk);
    chk({24'h0, control_word}, 32'h0);
    w[0] = $urandom();
    op(1'b0, 5'h08, w[0]);
    op(1'b0, 5'h18, ~w[0]);
    op(1'b0, 5'h0C, ~w[0]);
    chk({24'h0, control_word}, {24'h0, w[0][7:0]});
    chk({22'h0, drive_status, sector_count}, {22'h0, v[9:0]});
    st = {3'h0, v[9:5], 3'h0, v[4:0], 8'h00, w[0][7:0]};
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(st);
      op(1'b1, {2'b00, rc[i]}, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      w[i] = $urandom();
      op(1'b0, 5'h0B, w[i]);
    end
    chk({31'h0, irq_pending}, 32'h0);
    op(1'b0, 5'h0B, ~w[0]);
    chk({31'h0, irq_pending}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(w[i]);
      op(1'b1, 5'h03, 32'h0);
    end
    op(1'b0, 5'h11, 32'h0);
    chk({31'h0, irq_pending}, 32'h0);
    op(1'b0, 5'h0A, w[1]);
    exp_q.push_back({24'h0, w[1][7:0]});
    op(1'b1, 5'h02, 32'h0);
    op(1'b0, 5'h0B, w[0]);
    op(1'b0, 5'h10, 32'h0);
    op(1'b0, 5'h0B, w[2]);
    exp_q.push_back(w[2]);
    op(1'b1, 5'h03, 32'h0);
    op(1'b0, 5'h14, 32'h0);
    chk({31'h0, auto_mode}, 32'h1);
    op(1'b0, 5'h0B, w[3]);
    exp_q.push_back(w[3]);
    op(1'b1, 5'h00, 32'h0);
    op(1'b0, 5'h13, 32'h0);
    chk({31'h0, auto_mode}, 32'h0);
    op(1'b0, 5'h09, {22'h0, v[19:10]});
    chk(drive_address, {22'h0, v[19:10]});
    chk({22'h0, tag_val[0]}, {22'h0, v[19:10]});
    op(1'b0, 5'h09, 32'h4000000D);
    op(1'b0, 5'h09, 32'h4000000E);
    chk({22'h0, tag_val[1]}, 32'h0000000D);
    for (int i = 0; i < 3; i++) begin
      op(1'b0, 5'h09, 32'h80000000 | (32'h1 << i));
      chk({22'h0, tag_val[2]}, 32'h1 << i);
    end
    tally_and_finish();
  end
endmodule

// [verilog/dpc_ctrl.sv]
// disk controller end: port command decode, data buffer and drive tag drive
`timescale 1ns/1ps
`include "dpc_params.svh"
// Functional notes
// - host carries select bit and five command lines
// - strobe only with valid command present
// - strobe and lines stable one microcycle
// - decode only when strobe and select high
// - identity 00 read, 01 write, 10 control
// - command bits pick path or preset action
// - answer read strobe only when accelerator low
// - addressed read places data on host bus
// - sync to 90 ns base clock, three per microcycle; host base clock here is 5 clocks, 100 ns
// - phase two gate high last 90 ns; host gate is 4 clocks, 80 ns
// - three tag lines qualify tag bus
// - seek: cylinder on bus, tag one
// - head select: head on bits 4:0, tag two
// - tags also start read, write, recalibrate
// - accept sector count and drive status lines
// - write codes: control, address, byte, word
// - control codes: clear count, irq, preset, auto
module dpc_ctrl (
  input wire logic clk,
  input wire logic rst,
  dpc_if.ctrl port,
  output logic irq_pending,
  output logic auto_mode,
  output logic [7:0] control_word,
  output logic [31:0] drive_address,
  output logic [4:0] sector_count,
  output logic [4:0] drive_status
);
  logic [2:0] cs_s;
  logic [2:0] rd_s;
  logic [2:0] clk_s;
  logic [2:0] sel_s;
  logic [2:0] acc_s;
  logic [4:0] cmd_s [3];
  logic cs_q;
  logic rd_q;
  logic bclk_q;
  logic cs_prev;
  logic rd_prev;
  logic bclk_prev;
  logic cmd_take;
  logic read_take;
  logic [1:0] ident;
  logic [2:0] code;
  logic [1:0] base_count;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [31:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic fifo_flush;
  logic [9:0] tag_bus_next;
  logic [2:0] tag_lines_next;
  logic load_tag;
  logic cmd_take_rd_word;
  logic read_word_now;
  logic [9:0] drv_s [3];

  // three stage synchronisers; a strobe or base clock change counts when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s <= '0;
      rd_s <= '0;
      clk_s <= '0;
      sel_s <= '0;
      acc_s <= '0;
      cmd_s[0] <= '0;
      cmd_s[1] <= '0;
      cmd_s[2] <= '0;
    end else begin
      cs_s <= {cs_s[1:0], port.command_strobe};
      rd_s <= {rd_s[1:0], port.read_strobe};
      clk_s <= {clk_s[1:0], port.base_clock};
      sel_s <= {sel_s[1:0], port.device_select_bit};
      acc_s <= {acc_s[1:0], port.accelerator_select};
      cmd_s[0] <= port.command_lines;
      cmd_s[1] <= cmd_s[0];
      cmd_s[2] <= cmd_s[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_q <= 1'b0;
      rd_q <= 1'b0;
      bclk_q <= 1'b0;
      cs_prev <= 1'b0;
      rd_prev <= 1'b0;
      bclk_prev <= 1'b0;
    end else begin
      if (cs_s[1] == cs_s[2]) begin
        cs_q <= cs_s[2];
      end
      if (rd_s[1] == rd_s[2]) begin
        rd_q <= rd_s[2];
      end
      if (clk_s[1] == clk_s[2]) begin
        bclk_q <= clk_s[2];
      end
      cs_prev <= cs_q;
      rd_prev <= rd_q;
      bclk_prev <= bclk_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_count <= '0;
    end else if (bclk_q && !bclk_prev) begin
      base_count <= (base_count == 2'h2) ? 2'h0 : base_count + 2'h1;
    end
  end

  assign cmd_take = cs_q && !cs_prev && sel_s[2];
  assign read_take = rd_q && !rd_prev && !acc_s[2];
  assign ident = cmd_s[2][`DPC_CMD_ID_HI:`DPC_CMD_ID_LO];
  assign code = cmd_s[2][`DPC_CMD_CODE_HI:0];

  // write byte and word into buffer
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data = port.host_wdata;
    if (cmd_take && ident == dpc_pkg::DPC_ID_WRITE) begin
      if (code == dpc_pkg::DPC_CODE_BYTE) begin
        fifo_in_valid = 1'b1;
        fifo_in_data = {24'h000000, port.host_wdata[7:0]};
      end else if (code == dpc_pkg::DPC_CODE_WORD) begin
        fifo_in_valid = 1'b1;
      end
    end
  end

  assign fifo_flush = cmd_take && ident == dpc_pkg::DPC_ID_CONTROL &&
    (code == dpc_pkg::DPC_CODE_CTRL || code == dpc_pkg::DPC_CODE_WORD);

  dpc_fifo #(.WIDTH(32), .DEPTH(`DPC_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // read class, selects word path or auto mode
  assign read_word_now = ident == dpc_pkg::DPC_ID_READ &&
    (code == dpc_pkg::DPC_CODE_WORD || code == dpc_pkg::DPC_CODE_BYTE);
  // a command arriving with the read strobe decides; else a standing one
  assign fifo_out_ready = read_take &&
    (auto_mode || (cmd_take ? read_word_now : cmd_take_rd_word));
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_take_rd_word <= 1'b0;
    end else if (read_take) begin
      cmd_take_rd_word <= 1'b0;
    end else if (cmd_take) begin
      cmd_take_rd_word <= read_word_now;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port.host_rdata <= '0;
      port.host_rdata_oe <= 1'b0;
    end else if (read_take) begin
      port.host_rdata_oe <= 1'b1;
      if (fifo_out_ready) begin
        port.host_rdata <= fifo_out_valid ? fifo_out_data : '0;
      end else begin
        port.host_rdata <= {3'h0, drive_status, 3'h0, sector_count, 8'h00, control_word};
      end
    end else if (!rd_q) begin
      port.host_rdata_oe <= 1'b0;
    end
  end

  // control word and address word; others ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      control_word <= `DPC_CTRL_RESET;
      drive_address <= '0;
    end else if (cmd_take && ident == dpc_pkg::DPC_ID_WRITE) begin
      if (code == dpc_pkg::DPC_CODE_CTRL) begin
        control_word <= port.host_wdata[7:0];
      end else if (code == dpc_pkg::DPC_CODE_ADDR) begin
        drive_address <= port.host_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_pending <= 1'b0;
      auto_mode <= 1'b0;
      port.drive_init <= 1'b0;
    end else begin
      port.drive_init <= 1'b0;
      if (fifo_in_valid && !fifo_in_ready) begin
        irq_pending <= 1'b1;
      end else if (cmd_take && ident == dpc_pkg::DPC_ID_CONTROL) begin
        if (code == dpc_pkg::DPC_CODE_ADDR) begin
          irq_pending <= 1'b0;
        end else if (code == dpc_pkg::DPC_CODE_WORD) begin
          auto_mode <= 1'b0;
          port.drive_init <= 1'b1;
        end else if (code == dpc_pkg::DPC_CODE_PAT) begin
          auto_mode <= 1'b1;
        end
      end
    end
  end

  // tag selection from address word: [31:30] picks tag, low bits bus
  always_comb begin
    tag_lines_next = 3'h0;
    tag_bus_next = drive_address[9:0];
    load_tag = cmd_take && ident == dpc_pkg::DPC_ID_WRITE &&
      code == dpc_pkg::DPC_CODE_ADDR;
    unique case (port.host_wdata[31:30])
      2'b00: tag_lines_next[`DPC_TAG_SEEK] = 1'b1;
      2'b01: begin
        tag_lines_next[`DPC_TAG_HEAD] = port.host_wdata[4:0] < 5'(`DPC_HEAD_COUNT);
        tag_bus_next = {5'h00, port.host_wdata[4:0]};
      end
      2'b10: tag_lines_next[`DPC_TAG_FUNC] = 1'b1;
      2'b11: tag_lines_next[`DPC_TAG_FUNC] = 1'b1;
    endcase
    if (port.host_wdata[31:30] != 2'b01) begin
      tag_bus_next = port.host_wdata[9:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port.drive_tag_lines <= '0;
      port.drive_tag_bus <= '0;
    end else if (load_tag) begin
      port.drive_tag_lines <= tag_lines_next;
      port.drive_tag_bus <= tag_bus_next;
    end else if (base_count == 2'h2 && bclk_q && !bclk_prev) begin
      port.drive_tag_lines <= '0;
    end
  end

  always_ff @(posedge clk) begin
    drv_s[0] <= {port.drive_write_protect, port.drive_ready, port.drive_on_cylinder,
      port.drive_seek_error, port.drive_fault, port.drive_sector_count};
    drv_s[1] <= drv_s[0];
    drv_s[2] <= drv_s[1];
    if (rst) begin
      sector_count <= '0;
      drive_status <= '0;
    end else if (drv_s[1] == drv_s[2]) begin
      {drive_status, sector_count} <= drv_s[2];
    end
  end
endmodule

// [verilog/dpc_fifo.sv]
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module dpc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// [verilog/dpc_host.sv]
// host end: issues port commands and read strobes with microcycle timing
`timescale 1ns/1ps
`include "dpc_params.svh"
module dpc_host (
  input wire logic clk,
  input wire logic rst,
  dpc_if.host port,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [4:0] req_command,
  input wire logic [31:0] req_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_data
);
  dpc_pkg::dpc_hstate_e state;
  logic [4:0] cyc;
  logic [2:0] bc;

  // base clock divider, phase two in last third
  always_ff @(posedge clk) begin
    if (rst) begin
      bc <= '0;
      port.base_clock <= 1'b0;
      port.phase_two_gate <= 1'b0;
    end else begin
      bc <= (bc == 3'(`DPC_BASE_CYC - 1)) ? 3'h0 : bc + 3'h1;
      port.base_clock <= bc < 3'(`DPC_BASE_CYC / 2);
      // high for the last four clocks of the strobe window
      port.phase_two_gate <= state != dpc_pkg::DPC_H_IDLE &&
        cyc >= 5'(`DPC_HOLD_CYC - 1 - `DPC_PHASE2_CYC) && cyc < 5'(`DPC_HOLD_CYC - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= dpc_pkg::DPC_H_IDLE;
      cyc <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      port.command_strobe <= 1'b0;
      port.device_select_bit <= 1'b0;
      port.command_lines <= '0;
      port.read_strobe <= 1'b0;
      port.accelerator_select <= 1'b0;
      port.host_wdata <= '0;
    end else begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      unique case (state)
        dpc_pkg::DPC_H_IDLE: begin
          if (req_valid && !req_ready) begin
            req_ready <= 1'b1;
            port.command_lines <= req_command;
            port.host_wdata <= req_wdata;
            port.device_select_bit <= 1'b1;
            port.command_strobe <= 1'b1;
            port.read_strobe <= req_read;
            port.accelerator_select <= 1'b0;
            cyc <= '0;
            state <= req_read ? dpc_pkg::DPC_H_READ : dpc_pkg::DPC_H_HOLD;
          end
        end
        dpc_pkg::DPC_H_HOLD, dpc_pkg::DPC_H_READ: begin
          cyc <= cyc + 5'h01;
          if (cyc == 5'(`DPC_HOLD_CYC - 1)) begin
            if (state == dpc_pkg::DPC_H_READ) begin
              rsp_valid <= 1'b1;
              rsp_data <= port.host_rdata;
            end
            port.command_strobe <= 1'b0;
            port.read_strobe <= 1'b0;
            port.device_select_bit <= 1'b0;
            state <= dpc_pkg::DPC_H_IDLE;
          end
        end
        default: state <= dpc_pkg::DPC_H_IDLE;
      endcase
    end
  end
endmodule

// [verilog/dpc_if.sv]
// port bus and drive tag link between host and disk controller
`timescale 1ns/1ps
interface dpc_if;
  logic command_strobe;
  logic device_select_bit;
  logic [4:0] command_lines;
  logic read_strobe;
  logic accelerator_select;
  logic phase_two_gate;
  logic base_clock;
  logic [31:0] host_wdata;
  logic [31:0] host_rdata;
  logic host_rdata_oe;
  logic [2:0] drive_tag_lines;
  logic [9:0] drive_tag_bus;
  logic drive_init;
  logic [4:0] drive_sector_count;
  logic drive_fault;
  logic drive_seek_error;
  logic drive_on_cylinder;
  logic drive_ready;
  logic drive_write_protect;
  modport host (
    output command_strobe, device_select_bit, command_lines, read_strobe,
    output accelerator_select, phase_two_gate, base_clock, host_wdata,
    input host_rdata, host_rdata_oe
  );
  modport ctrl (
    input command_strobe, device_select_bit, command_lines, read_strobe,
    input accelerator_select, phase_two_gate, base_clock, host_wdata,
    output host_rdata, host_rdata_oe,
    output drive_tag_lines, drive_tag_bus, drive_init,
    input drive_sector_count, drive_fault, drive_seek_error,
    input drive_on_cylinder, drive_ready, drive_write_protect
  );
endinterface

// [verilog/dpc_params.svh]
// timing counts, field positions and codes for the disk port command decoder
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH
`define DPC_CLK_NS 20
`define DPC_BASE_CLK_NS 90
`define DPC_MICROCYCLE_NS 270
`define DPC_PHASE2_NS 90
`define DPC_BASE_CYC ((`DPC_BASE_CLK_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_MICRO_CYC (3 * `DPC_BASE_CYC)
`define DPC_PHASE2_CYC (`DPC_PHASE2_NS / `DPC_CLK_NS)
`define DPC_HOLD_CYC ((`DPC_MICROCYCLE_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_CMD_ID_HI 4
`define DPC_CMD_ID_LO 3
`define DPC_CMD_CODE_HI 2
`define DPC_TAG_SEEK 0
`define DPC_TAG_HEAD 1
`define DPC_TAG_FUNC 2
`define DPC_FUNC_READ 10'h001
`define DPC_FUNC_WRITE 10'h002
`define DPC_FUNC_RECAL 10'h004
`define DPC_HEAD_COUNT 14
`define DPC_FIFO_DEPTH 4
`define DPC_CTRL_RESET 8'h00
`endif

// [verilog/dpc_pkg.sv]
// types shared by both ends of the disk port command decoder
package dpc_pkg;
  typedef enum logic [1:0] {
    DPC_ID_READ = 2'b00,
    DPC_ID_WRITE = 2'b01,
    DPC_ID_CONTROL = 2'b10,
    DPC_ID_NONE = 2'b11
  } dpc_ident_e;
  typedef enum logic [2:0] {
    DPC_CODE_CTRL = 3'b000,
    DPC_CODE_ADDR = 3'b001,
    DPC_CODE_BYTE = 3'b010,
    DPC_CODE_WORD = 3'b011,
    DPC_CODE_PAT = 3'b100,
    DPC_CODE_POS = 3'b101,
    DPC_CODE_U6 = 3'b110,
    DPC_CODE_U7 = 3'b111
  } dpc_code_e;
  typedef enum logic [1:0] {
    DPC_H_IDLE = 2'b00,
    DPC_H_HOLD = 2'b01,
    DPC_H_READ = 2'b10
  } dpc_hstate_e;
endpackage
